// *** logic/tlb_translation_lookup.sv ***
// Purpose: 16-entry fully associative lookup with page sizes and permissions
// Assumes: software keeps valid entries from overlapping
// Notes:   lookup answer is combinational in the request cycle
//
// Overview of operation
// [RULE1] process id keeps 8 bits, upper read zero
// [RULE2] current process id always driven out
// [RULE3] zero translation id matches any process id
// [RULE4] candidate needs page number and space match
// [RULE5] nonzero translation id must equal process id
// [RULE6] size field picks compared page number bits
// [RULE7] real address is page number plus offset
// [RULE8] supervisor mode uses supervisor read/write/execute bits
// [RULE9] user mode uses user read/write/execute bits
// [RULE10] refused hit raises instruction or data storage
// [RULE11] sixteen entries all compared in parallel
// [RULE12] multiple hits give no exception, undefined address; code still raises a storage interrupt if no hit entry grants the access
// [RULE13] protected entries survive invalidate and flash
// [RULE14] entry write clearing valid removes protected entry
// [RULE15] address invalidate kills matching unprotected entries
// [RULE16] software picks victim into entry select
// [RULE17] miss copies next victim into entry select
// [RULE18] no matching entry signals translation error
// [RULE19] same-cycle answer, reset clears all valid
`timescale 1ns/100ps
module tlb_translation_lookup (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // process id register
  input  wire logic                 pid_wr_en,
  input  wire logic [31:0]          pid_wr_data,
  output wire logic [31:0]          pid_rd_data,
  output wire logic [7:0]           current_pid_out,
  // machine state bits
  input  wire logic                 instr_space_bit,
  input  wire logic                 data_space_bit,
  input  wire logic                 user_mode_bit,
  // lookup
  input  wire tlb_pkg::lookup_req_t req,
  output wire tlb_pkg::lookup_rsp_t rsp,
  output wire logic                 instr_tlb_error,
  output wire logic                 data_tlb_error,
  output wire logic                 instr_storage_interrupt,
  output wire logic                 data_storage_interrupt,
  // assist register zero
  input  wire logic                 asr0_wr_en,
  input  wire logic [3:0]           asr0_wr_select,
  input  wire logic [3:0]           asr0_wr_victim,
  output wire logic [3:0]           entry_select,
  output wire logic [3:0]           next_victim,
  // entry write and read
  input  wire logic                 entry_wr_en,
  input  wire tlb_pkg::tlb_entry_t  entry_wr_data,
  output wire tlb_pkg::tlb_entry_t  entry_rd_data,
  // invalidation
  input  wire logic                 inv_en,
  input  wire logic                 invalidate_everything_cmd,
  input  wire logic [31:0]          inv_addr,
  input  wire logic                 flash_invalidate_bit
);

  tlb_pkg::tlb_entry_t entries_q [tlb_pkg::NUM_ENTRIES];
  logic [7:0]          process_id_reg_q;
  logic [3:0]          entry_select_q;
  logic [3:0]          next_victim_q;

  logic [15:0]         cand;
  logic [15:0]         hit_vec;
  logic [15:0]         kill;
  logic [15:0]         valid_d;
  tlb_pkg::tlb_entry_t hit_entry;
  logic [19:0]         hit_mask;
  logic [19:0]         ea_pn;
  logic [19:0]         inv_pn;
  logic                cur_space;
  logic                any_hit;
  logic                multi_hit;
  logic                is_fetch;
  logic                perm_ok;
  logic                miss_err;
  logic                perm_err;

  // compared page number bits; two fewer bits per size step
  function automatic logic [19:0] page_mask(input logic [3:0] size);
    logic [4:0] sh;
    sh = {size, 1'h0} - tlb_pkg::SIZE_SHIFT0; // see [RULE6]
    page_mask = tlb_pkg::EPN_ONES << sh;
  endfunction

  // reserved size codes never match, so a bad entry is simply inert
  function automatic logic page_match(input tlb_pkg::tlb_entry_t e,
                                      input logic [19:0] pn);
    logic ok;
    ok = (e.size >= tlb_pkg::SIZE_MIN) && (e.size <= tlb_pkg::SIZE_MAX);
    page_match = ok && (((e.effective_page_number ^ pn) &
                         page_mask(e.size)) == '0); // see [RULE6]
  endfunction

  assign ea_pn     = req.ea[31:12];
  assign inv_pn    = inv_addr[31:12];
  assign is_fetch  = (req.kind == tlb_pkg::ACC_FETCH);
  assign cur_space = is_fetch ? instr_space_bit : data_space_bit;

  // every entry is compared at once; see [RULE11]
  for (genvar i = 0; i < tlb_pkg::NUM_ENTRIES; i++) begin : g_cam
    assign cand[i] = entries_q[i].valid &&
                     page_match(entries_q[i], ea_pn) &&
                     (entries_q[i].translation_space == cur_space); // see [RULE4]
    assign hit_vec[i] = cand[i] &&
      ((entries_q[i].translation_id == tlb_pkg::TID_GLOBAL) || // see [RULE3]
       (entries_q[i].translation_id == process_id_reg_q));    // see [RULE5]
    // address invalidate ignores space and id, but spares protected ones
    assign kill[i] = inv_en && !entries_q[i].invalidation_protect &&
                     (invalidate_everything_cmd ||
                      page_match(entries_q[i], inv_pn)); // see [RULE15]
    assign valid_d[i] = entries_q[i].valid && !kill[i] &&
      !(flash_invalidate_bit &&
        !entries_q[i].invalidation_protect); // see [RULE13]
  end

  // overlapping hits are OR-ed together; the result is meaningless
  always_comb begin
    hit_entry = '0;
    for (int i = 0; i < tlb_pkg::NUM_ENTRIES; i++) begin
      if (hit_vec[i]) begin
        hit_entry = hit_entry | entries_q[i]; // see [RULE12]
      end
    end
  end

  assign any_hit   = |hit_vec;
  assign multi_hit = (hit_vec & (hit_vec - 16'h0001)) != '0; // see [RULE12]
  assign hit_mask  = page_mask(hit_entry.size);

  assign perm_ok =
    is_fetch ? (user_mode_bit ? hit_entry.user_exec_ok
                              : hit_entry.supervisor_exec_ok) :
    (req.kind == tlb_pkg::ACC_STORE) ?
               (user_mode_bit ? hit_entry.user_write_ok   // see [RULE9]
                              : hit_entry.supervisor_write_ok) :
               (user_mode_bit ? hit_entry.user_read_ok
                              : hit_entry.supervisor_read_ok); // see [RULE8]

  assign miss_err = req.valid && !any_hit; // see [RULE18]
  assign perm_err = req.valid && any_hit && !perm_ok; // see [RULE10]

  // answer in the request cycle; see [RULE19]
  assign rsp.hit       = req.valid && any_hit;
  assign rsp.allowed   = req.valid && any_hit && perm_ok;
  assign rsp.multi_hit = req.valid && multi_hit;
  assign rsp.real_addr = {(hit_entry.real_page_number & hit_mask) |
                          (ea_pn & ~hit_mask),
                          req.ea[11:0]}; // see [RULE7]

  assign instr_tlb_error         = miss_err && is_fetch;
  assign data_tlb_error          = miss_err && !is_fetch;
  assign instr_storage_interrupt = perm_err && is_fetch;
  assign data_storage_interrupt  = perm_err && !is_fetch;

  assign pid_rd_data     = {tlb_pkg::PID_UPPER, process_id_reg_q}; // see [RULE1]
  assign current_pid_out = process_id_reg_q; // see [RULE2]
  assign entry_select    = entry_select_q;
  assign next_victim     = next_victim_q;
  assign entry_rd_data   = entries_q[entry_select_q];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      process_id_reg_q <= tlb_pkg::PID_RST;
    end else if (pid_wr_en) begin
      process_id_reg_q <= pid_wr_data[7:0]; // see [RULE1]
    end
  end

  // a miss in the same cycle as a software write takes precedence
  always_ff @(posedge clk) begin
    if (!rstn) begin
      entry_select_q <= tlb_pkg::ENTRY_SELECT_RST;
      next_victim_q  <= tlb_pkg::NV_RST;
    end else begin
      if (miss_err) begin
        entry_select_q <= next_victim_q; // see [RULE17]
      end else if (asr0_wr_en) begin
        entry_select_q <= asr0_wr_select; // see [RULE16]
      end
      if (asr0_wr_en) begin
        next_victim_q <= asr0_wr_victim;
      end
    end
  end

  // entry write is applied last so it beats any same-cycle invalidate
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < tlb_pkg::NUM_ENTRIES; i++) begin
        entries_q[i] <= '0; // see [RULE19]
      end
    end else begin
      for (int i = 0; i < tlb_pkg::NUM_ENTRIES; i++) begin
        entries_q[i].valid <= valid_d[i];
      end
      if (entry_wr_en) begin
        entries_q[entry_select_q] <= entry_wr_data; // see [RULE14]
      end
    end
  end

  property p_pid_upper;
    @(posedge clk) disable iff (!rstn)
      pid_rd_data[31:8] == tlb_pkg::PID_UPPER;
  endproperty
  a_pid_upper: assert property (p_pid_upper) // see [RULE1]
    else $error("process id upper bits not zero");

  property p_pid_out;
    @(posedge clk) disable iff (!rstn)
      pid_wr_en |=> current_pid_out == $past(pid_wr_data[7:0]);
  endproperty
  a_pid_out: assert property (p_pid_out) // see [RULE2]
    else $error("current process id not updated");

  property p_miss_err;
    @(posedge clk) disable iff (!rstn)
      (req.valid && hit_vec == '0) |->
        (instr_tlb_error == is_fetch) && (data_tlb_error == !is_fetch) &&
        !rsp.hit;
  endproperty
  a_miss_err: assert property (p_miss_err) // see [RULE18]
    else $error("miss not signalled on the right error");

  property p_victim;
    @(posedge clk) disable iff (!rstn)
      (instr_tlb_error || data_tlb_error) |=>
        entry_select == $past(next_victim);
  endproperty
  a_victim: assert property (p_victim) // see [RULE17]
    else $error("next victim not copied on miss");

  property p_perm_refuse;
    @(posedge clk) disable iff (!rstn)
      (rsp.hit && !rsp.allowed) |->
        (instr_storage_interrupt || data_storage_interrupt) &&
        !(instr_tlb_error || data_tlb_error);
  endproperty
  a_perm_refuse: assert property (p_perm_refuse) // see [RULE10]
    else $error("refused access raised no storage interrupt");

  property p_user_fetch;
    @(posedge clk) disable iff (!rstn)
      (rsp.hit && !rsp.multi_hit && is_fetch && user_mode_bit) |->
        rsp.allowed == hit_entry.user_exec_ok;
  endproperty
  a_user_fetch: assert property (p_user_fetch) // see [RULE9]
    else $error("user fetch permission wrong");

  property p_sup_store;
    @(posedge clk) disable iff (!rstn)
      (rsp.hit && !rsp.multi_hit && !user_mode_bit &&
       req.kind == tlb_pkg::ACC_STORE) |->
        rsp.allowed == hit_entry.supervisor_write_ok;
  endproperty
  a_sup_store: assert property (p_sup_store) // see [RULE8]
    else $error("supervisor store permission wrong");

  property p_offset;
    @(posedge clk) disable iff (!rstn)
      rsp.hit |-> rsp.real_addr[11:0] == req.ea[11:0];
  endproperty
  a_offset: assert property (p_offset) // see [RULE7]
    else $error("page offset not passed through");

  property p_protect;
    @(posedge clk) disable iff (!rstn)
      ((flash_invalidate_bit || inv_en) && !entry_wr_en &&
       entries_q[entry_select_q].valid &&
       entries_q[entry_select_q].invalidation_protect) |=>
        entries_q[$past(entry_select_q)].valid;
  endproperty
  a_protect: assert property (p_protect) // see [RULE13]
    else $error("protected entry lost by invalidation");

  property p_entry_write;
    @(posedge clk) disable iff (!rstn)
      entry_wr_en |=>
        entries_q[$past(entry_select_q)] == $past(entry_wr_data);
  endproperty
  a_entry_write: assert property (p_entry_write) // see [RULE14]
    else $error("entry write not stored");

  property p_no_hit_quiet;
    @(posedge clk) disable iff (!rstn)
      !rsp.hit |->
        !rsp.allowed && !instr_storage_interrupt && !data_storage_interrupt;
  endproperty
  a_no_hit_quiet: assert property (p_no_hit_quiet) // see [RULE10]
    else $error("access allowed or refused without a hit");

  property p_pid_hold;
    @(posedge clk) disable iff (!rstn)
      !pid_wr_en |=> $stable(current_pid_out);
  endproperty
  a_pid_hold: assert property (p_pid_hold) // see [RULE2]
    else $error("process id changed without a write");

  property p_reset_clear;
    @(posedge clk)
      !rstn |=> hit_vec == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) // see [RULE19]
    else $error("entry still hits after reset");

  property p_hit_space;
    @(posedge clk) disable iff (!rstn)
      (rsp.hit && !rsp.multi_hit) |->
        hit_entry.translation_space == cur_space;
  endproperty
  a_hit_space: assert property (p_hit_space) // see [RULE4]
    else $error("hit in the wrong address space");

  property p_real_page;
    @(posedge clk) disable iff (!rstn)
      (rsp.hit && !rsp.multi_hit && hit_entry.size == tlb_pkg::SIZE_MIN) |->
        rsp.real_addr[31:12] == hit_entry.real_page_number;
  endproperty
  a_real_page: assert property (p_real_page) // see [RULE7]
    else $error("real page number not used on a small page");

  property p_user_load;
    @(posedge clk) disable iff (!rstn)
      (rsp.hit && !rsp.multi_hit && user_mode_bit &&
       req.kind == tlb_pkg::ACC_LOAD) |->
        rsp.allowed == hit_entry.user_read_ok;
  endproperty
  a_user_load: assert property (p_user_load) // see [RULE9]
    else $error("user load permission wrong");

  property p_select_hold;
    @(posedge clk) disable iff (!rstn)
      (!miss_err && !asr0_wr_en) |=> $stable(entry_select);
  endproperty
  a_select_hold: assert property (p_select_hold) // see [RULE16]
    else $error("entry select changed without a cause");

  property p_multi_quiet;
    @(posedge clk) disable iff (!rstn)
      rsp.multi_hit |-> !instr_tlb_error && !data_tlb_error;
  endproperty
  a_multi_quiet: assert property (p_multi_quiet) // see [RULE12]
    else $error("multiple hit reported an error");

endmodule

// *** logic/tlb_pkg.sv ***
// Purpose: shared types and constants of the translation lookaside buffer
// Assumes: 32-bit effective and real addresses, 4 KB smallest page
// Notes:   entry layout holds only what the lookup and invalidation use
package tlb_pkg;
  localparam int          NUM_ENTRIES = 16;
  localparam int          IDX_W       = 4;
  localparam int          PID_W       = 8;
  localparam int          REG_W       = 32;
  localparam int          EPN_W       = 20;
  localparam int          OFFSET_W    = 12;
  localparam int          SIZE_W      = 4;
  localparam logic [3:0]  SIZE_MIN    = 4'h1;
  localparam logic [3:0]  SIZE_MAX    = 4'h9;
  localparam logic [19:0] EPN_ONES    = 20'hFFFFF;
  localparam logic [4:0]  SIZE_SHIFT0 = 5'h02;
  localparam logic [7:0]  PID_RST     = 8'h00;
  localparam logic [7:0]  TID_GLOBAL  = 8'h00;
  localparam logic [23:0] PID_UPPER   = 24'h000000;
  localparam logic [3:0]  ENTRY_SELECT_RST    = 4'h0;
  localparam logic [3:0]  NV_RST      = 4'h0;

  typedef enum logic [1:0] {
    ACC_FETCH,
    ACC_LOAD,
    ACC_STORE
  } access_kind_t;

  typedef struct packed {
    logic        valid;
    logic        translation_space;
    logic [7:0]  translation_id;
    logic [19:0] effective_page_number;
    logic [19:0] real_page_number;
    logic [3:0]  size;
    logic        supervisor_read_ok;
    logic        supervisor_write_ok;
    logic        supervisor_exec_ok;
    logic        user_read_ok;
    logic        user_write_ok;
    logic        user_exec_ok;
    logic        invalidation_protect;
  } tlb_entry_t;

  typedef struct packed {
    logic         valid;
    access_kind_t kind;
    logic [31:0]  ea;
  } lookup_req_t;

  typedef struct packed {
    logic        hit;
    logic        allowed;
    logic        multi_hit;
    logic [31:0] real_addr;
  } lookup_rsp_t;
endpackage

// *** tb/core_model.sv ***
// Purpose: stand-in for the fetch and load/store address generators
// Assumes: one lookup per cycle, launched just after the rising edge
// Notes:   an idle address flips so a stale value never matches by luck
`timescale 1ns/100ps
module core_model (
  // clock
  input  wire logic            clk,
  // lookup request and machine state
  output tlb_pkg::lookup_req_t req,
  output logic                 instr_space_bit,
  output logic                 data_space_bit,
  output logic                 user_mode_bit
);
  initial begin
    req             = '0;
    instr_space_bit = 1'h0;
    data_space_bit  = 1'h0;
    user_mode_bit   = 1'h0;
  end

  // request stands until the next call; answer sampled at the falling edge
  task automatic look(input tlb_pkg::access_kind_t k,
                      input logic [31:0] a, input logic u, input logic s);
    @(posedge clk);
    req             <= {1'h1, k, a};
    user_mode_bit   <= u;
    instr_space_bit <= s;
    data_space_bit  <= s;
    @(negedge clk);
  endtask

  task automatic idle();
    @(posedge clk);
    req.valid <= 1'h0;
    req.ea    <= ~req.ea;
  endtask
endmodule

// *** tb/tlb_translation_lookup_test.sv ***
// Purpose: self-checking bench for the translation lookup
// Assumes: combinational answer, looked at on the falling edge
// Notes:   the request goes idle before entry writes so no miss copy
//          overrides the select written by software
`timescale 1ns/100ps
module tlb_translation_lookup_test;
  logic                clk = 1'h0;
  logic                rstn = 1'h0;
  logic                pid_wr_en = 1'h0;
  logic [31:0]         pid_wr_data = '0;
  logic                asr0_wr_en = 1'h0;
  logic [3:0]          sel = 4'h0;
  logic [3:0]          vic = 4'h0;
  logic                entry_wr_en = 1'h0;
  tlb_pkg::tlb_entry_t entry_wr_data = '0;
  logic                inv_en = 1'h0;
  logic                inv_every = 1'h0;
  logic [31:0]         inv_addr = '0;
  logic                flash = 1'h0;
  wire [31:0]          pid_rd_data;
  wire [7:0]           current_pid_out;
  wire                 ibit, dbit, umode, ierr, derr, iint, dint;
  wire [3:0]           entry_select, next_victim;
  wire tlb_pkg::lookup_req_t req;
  wire tlb_pkg::lookup_rsp_t rsp;
  wire tlb_pkg::tlb_entry_t  entry_rd_data;
  int                  mismatches = 0;
  int                  comparisons = 0;

  always #4 clk = ~clk;

  core_model core (.clk(clk), .req(req), .instr_space_bit(ibit),
    .data_space_bit(dbit), .user_mode_bit(umode));

  tlb_translation_lookup uut (.clk(clk), .rstn(rstn),
    .pid_wr_en(pid_wr_en), .pid_wr_data(pid_wr_data),
    .pid_rd_data(pid_rd_data), .current_pid_out(current_pid_out),
    .instr_space_bit(ibit), .data_space_bit(dbit), .user_mode_bit(umode),
    .req(req), .rsp(rsp), .instr_tlb_error(ierr), .data_tlb_error(derr),
    .instr_storage_interrupt(iint), .data_storage_interrupt(dint),
    .asr0_wr_en(asr0_wr_en), .asr0_wr_select(sel), .asr0_wr_victim(vic),
    .entry_select(entry_select), .next_victim(next_victim),
    .entry_wr_en(entry_wr_en), .entry_wr_data(entry_wr_data),
    .entry_rd_data(entry_rd_data), .inv_en(inv_en),
    .invalidate_everything_cmd(inv_every), .inv_addr(inv_addr),
    .flash_invalidate_bit(flash));

  task automatic end_of_test();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // valid, space 0 and every permission set unless changed afterwards
  function automatic tlb_pkg::tlb_entry_t mk(input logic [19:0] pg,
      input logic [19:0] rp, input logic [3:0] sz, input logic [7:0] id,
      input logic prot);
    tlb_pkg::tlb_entry_t e;
    e = '1;
    e.translation_space     = 1'h0;
    e.translation_id        = id;
    e.effective_page_number = pg;
    e.real_page_number      = rp;
    e.size                  = sz;
    e.invalidation_protect  = prot;
    return e;
  endfunction

  task automatic put(input logic [3:0] i, input tlb_pkg::tlb_entry_t e);
    core.idle();
    @(posedge clk);
    asr0_wr_en <= 1'h1; // software picks the victim
    sel <= i;
    @(posedge clk);
    asr0_wr_en <= 1'h0;
    entry_wr_en <= 1'h1; // entry written at the select picked by software
    entry_wr_data <= e;
    @(posedge clk);
    entry_wr_en <= 1'h0;
  endtask

  task automatic inv(input logic [31:0] a, input logic ev, input logic fl);
    @(posedge clk);
    inv_en <= !fl;
    inv_every <= ev;
    inv_addr <= a;
    flash <= fl;
    @(posedge clk);
    inv_en <= 1'h0;
    inv_every <= 1'h0;
    flash <= 1'h0;
  endtask

  task automatic hit_at(input logic [3:0] i, input logic h);
    core.look(tlb_pkg::ACC_FETCH, {16'h4000, i, 12'h000}, 1'h0, 1'h0);
    chk(rsp.hit, h);
  endtask

  task automatic t_first();
    chk(pid_rd_data, 32'h0); // cleared by reset
    core.look(tlb_pkg::ACC_FETCH, 32'h0, 1'h0, 1'h0);
    chk(ierr, 1'h1); // no valid entry
    chk(rsp.hit, 1'h0);
  endtask

  task automatic t_pid();
    @(posedge clk);
    pid_wr_en <= 1'h1;
    pid_wr_data <= 32'hFFFFFFA5;
    @(posedge clk);
    pid_wr_en <= 1'h0;
    @(negedge clk);
    chk(pid_rd_data, 32'h000000A5); // upper bits zero
    chk(current_pid_out, 8'hA5);
  endtask

  task automatic t_victim();
    @(posedge clk);
    vic <= 4'h7;
    put(4'h2, mk(20'h00022, 20'h00022, 4'h1, 8'h00, 1'h0));
    chk(entry_select, 4'h2);
    @(negedge clk);
    chk(next_victim, 4'h7); // victim loaded by software
    chk(entry_rd_data.real_page_number, 20'h00022);
    core.look(tlb_pkg::ACC_LOAD, 32'hFFFFF000, 1'h0, 1'h0);
    chk(derr, 1'h1); // data miss
    core.idle();
    @(negedge clk);
    chk(entry_select, 4'h7); // victim copied on miss
  endtask

  task automatic t_match();
    put(4'h3, mk(20'h12345, 20'hABCDE, 4'h1, 8'h00, 1'h0));
    core.look(tlb_pkg::ACC_FETCH, 32'h12345678, 1'h0, 1'h0);
    chk(rsp.hit, 1'h1); // global id
    chk(rsp.real_addr, 32'hABCDE678);
    core.look(tlb_pkg::ACC_FETCH, 32'h12345678, 1'h0, 1'h1);
    chk(ierr, 1'h1); // other space
    core.look(tlb_pkg::ACC_STORE, 32'h12345678, 1'h0, 1'h1);
    chk(derr, 1'h1);
    put(4'h3, mk(20'h12345, 20'hABCDE, 4'h1, 8'hA6, 1'h0));
    core.look(tlb_pkg::ACC_LOAD, 32'h12345678, 1'h0, 1'h0);
    chk(rsp.hit, 1'h0); // foreign id
    put(4'h3, mk(20'h12345, 20'hABCDE, 4'h1, 8'hA5, 1'h0));
    core.look(tlb_pkg::ACC_LOAD, 32'h12345678, 1'h0, 1'h0);
    chk(rsp.hit, 1'h1);
  endtask

  task automatic t_size();
    logic [31:0] m, a;
    for (int s = 1; s <= 9; s++) begin
      m = (32'h1 << (10 + 2 * s)) - 32'h1;
      a = 32'hA5A5A000 ^ ((m >> 1) + 32'h1);
      put(4'h0, mk(20'hA5A5A, 20'h3C3C3, 4'(s), 8'h00, 1'h0));
      core.look(tlb_pkg::ACC_LOAD, a, 1'h0, 1'h0);
      chk(rsp.real_addr, (32'h3C3C3000 & ~m) | (a & m));
      core.look(tlb_pkg::ACC_LOAD, 32'hA5A5A000 ^ (m + 32'h1), 1'h0, 1'h0);
      chk(rsp.hit, 1'h0); // lowest compared bit
    end
  endtask

  task automatic t_perm();
    tlb_pkg::tlb_entry_t e;
    logic ok;
    for (int b = 0; b < 6; b++) begin
      e = mk(20'h00077, 20'h00011, 4'h1, 8'h00, 1'h0);
      {e.supervisor_read_ok, e.supervisor_write_ok, e.supervisor_exec_ok,
       e.user_read_ok, e.user_write_ok, e.user_exec_ok} = 6'h20 >> b;
      put(4'h1, e);
      for (int u = 0; u < 2; u++)
        for (int j = 0; j < 3; j++) begin
          ok = (b == u * 3 + (j == 0 ? 2 : j - 1));
          core.look(tlb_pkg::access_kind_t'(j), 32'h00077ABC, u[0], 1'h0);
          chk(rsp.allowed, ok);
          chk(iint, j == 0 && !ok); // fetch refusal
          chk(dint, j != 0 && !ok); // data refusal
        end
    end
  endtask

  task automatic t_inv();
    tlb_pkg::tlb_entry_t e;
    @(posedge clk);
    vic <= 4'h0; // misses leave select on protected entry 0
    for (int i = 15; i >= 0; i--)
      put(4'(i), mk({16'h4000, 4'(i)}, 20'(i), 4'h1, 8'h00, i % 2 == 0));
    for (int i = 0; i < 16; i++)
      hit_at(4'(i), 1'h1); // all entries searched
    inv({20'h40001, 12'h000}, 1'h0, 1'h0);
    hit_at(4'h1, 1'h0); // addressed entry gone
    inv({20'h40000, 12'h000}, 1'h0, 1'h0);
    hit_at(4'h0, 1'h1); // protected kept
    inv(32'h0, 1'h1, 1'h0);
    hit_at(4'h3, 1'h0);
    hit_at(4'h2, 1'h1);
    put(4'h5, mk(20'h40005, 20'h00005, 4'h1, 8'h00, 1'h0));
    inv(32'h0, 1'h0, 1'h1);
    hit_at(4'h5, 1'h0); // flash
    hit_at(4'h4, 1'h1);
    e = mk(20'h40004, 20'h00004, 4'h1, 8'h00, 1'h1);
    e.valid = 1'h0;
    put(4'h4, e);
    hit_at(4'h4, 1'h0);
    put(4'h6, mk(20'h40002, 20'h00002, 4'h1, 8'h00, 1'h0));
    hit_at(4'h2, 1'h1);
    chk(rsp.multi_hit, 1'h1); // overlap flagged
    chk(ierr | iint, 1'h0); // no exception
  endtask

  // a second reset mid-run must drop protected entries too
  task automatic t_reset2();
    @(posedge clk);
    rstn <= 1'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    hit_at(4'h0, 1'h0);
    chk(current_pid_out, 8'h00);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    t_first();
    t_pid();
    t_victim();
    t_match();
    t_size();
    t_perm();
    t_inv();
    t_reset2();
    end_of_test();
  end
endmodule
